// ==== logic/cfr_regs.sv ====
/*
  configuration register slice: power/boot, reserved, test control and
  ecp level / ir routing registers behind an index/data port.
  assumes a single-cycle strobe master; resetn_i is the power-on reset,
  hard_reset_i a synchronous level from logic on the same clock.
*/
// The address-and-strobe port was left to the implementer.
// Operation
// - bit 7 enables floppy auto powerdown
// - power reg por 00, hard reset clears [7:4]
// - index eight reserved, reads 00
// - test reg only in config, index 09
// - ecp reg only in config, index 0a
// - low bits hold ecp fifo level
// - bits 5:4 ignore writes, read 0
// - ecp por 00, hard reset clears [7:6]
// - route field selects com, ir, reserved, off
`timescale 1ns/1ps
module cfr_regs (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hard_reset_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic config_state_o,
  output logic fdc_auto_pd_o,
  output logic [2:0] ecp_fifo_level_o,
  output cfr_pkg::cfr_route_s route_ctl_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic cfg_mode;
  logic next_cfg_mode;
  logic [7:0] config_index_reg;
  logic [7:0] next_index;
  logic [7:0] power_boot_config;
  logic [7:0] next_power;
  logic [7:0] test_control;
  logic [7:0] next_test;
  logic [7:0] ecp_level_ir_route;
  logic [7:0] next_ecp;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic fdc_apd;
  logic [2:0] ecp_level;
  logic wr_data;
  logic sel_pwr;
  logic sel_test;
  logic sel_ecp;
  logic sel_rsvd;
  logic rd_data;

  // ----------------------------------------------------------------
  // selects
  // ----------------------------------------------------------------
  // data port only decodes inside configuration state
  assign wr_data = wr_i && (addr_i == cfr_pkg::ADDR_DATA) && cfg_mode;
  assign rd_data = rd_i && (addr_i == cfr_pkg::ADDR_DATA) && cfg_mode;
  assign sel_pwr = config_index_reg == cfr_pkg::IDX_POWER_BOOT;
  assign sel_rsvd = config_index_reg == cfr_pkg::IDX_RSVD_EIGHT;
  assign sel_test = config_index_reg == cfr_pkg::IDX_TEST_CTRL;
  assign sel_ecp = config_index_reg == cfr_pkg::IDX_ECP_IR;

  // ----------------------------------------------------------------
  // next register values
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cfg_mode = cfg_mode;
    next_index = config_index_reg;
    next_power = power_boot_config;
    next_test = test_control;
    next_ecp = ecp_level_ir_route;
    if (wr_i && addr_i == cfr_pkg::ADDR_MODE)
      next_cfg_mode = wdata_i[0];
    if (wr_i && addr_i == cfr_pkg::ADDR_INDEX && cfg_mode)
      next_index = wdata_i;
    if (wr_data && sel_pwr)
      next_power = wdata_i;
    if (wr_data && sel_test)
      next_test = wdata_i;
    if (wr_data && sel_ecp)
      next_ecp = wdata_i & cfr_pkg::ECP_WRITE_MASK;
    // index eight has no storage, writes vanish
    if (hard_reset_i)
    begin
      next_power = next_power & cfr_pkg::PWR_HARD_KEEP;
      next_ecp = next_ecp & cfr_pkg::ECP_HARD_KEEP;
    end
  end

  // register the next values
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cfg_mode <= 1'b0;
      config_index_reg <= cfr_pkg::POR_VALUE;
      power_boot_config <= cfr_pkg::POR_VALUE;
      test_control <= cfr_pkg::POR_VALUE;
      ecp_level_ir_route <= cfr_pkg::POR_VALUE;
    end
    else
    begin
      cfg_mode <= next_cfg_mode;
      config_index_reg <= next_index;
      power_boot_config <= next_power;
      test_control <= next_test;
      ecp_level_ir_route <= next_ecp;
    end
  end

  // ----------------------------------------------------------------
  // read data and outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        cfr_pkg::ADDR_INDEX: next_rdata = cfg_mode ? config_index_reg : 8'h00;
        cfr_pkg::ADDR_MODE: next_rdata = {7'h00, cfg_mode};
        cfr_pkg::ADDR_DATA:
        begin
          if (!cfg_mode)
            next_rdata = 8'h00;
          else if (sel_pwr)
            next_rdata = power_boot_config;
          else if (sel_rsvd)
            next_rdata = cfr_pkg::RSVD_EIGHT_VALUE;
          else if (sel_test)
            next_rdata = test_control;
          else if (sel_ecp)
            next_rdata = ecp_level_ir_route & cfr_pkg::ECP_WRITE_MASK;
          else
            next_rdata = 8'h00;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // output flops, loaded on the same edge as the registers
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      rdata <= 8'h00;
      fdc_apd <= 1'b0;
      ecp_level <= 3'h0;
    end
    else
    begin
      rdata <= next_rdata;
      fdc_apd <= next_power[cfr_pkg::FDC_APD_BIT];
      ecp_level <= next_ecp[cfr_pkg::ECP_LEVEL_LSB +: cfr_pkg::ECP_LEVEL_W];
    end
  end

  // outputs straight from their flops
  assign rdata_o = rdata;
  assign config_state_o = cfg_mode;
  assign fdc_auto_pd_o = fdc_apd;
  assign ecp_fifo_level_o = ecp_level;

  // routing decode
  cfr_route_dec u_route (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .route_i(next_ecp[cfr_pkg::IR_ROUTE_LSB +: 2]),
    .ctl_o(route_ctl_o)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // all checks run on the one clock, off during power-on reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_fdc_enable_follows: assert property (
    wr_data && sel_pwr && !hard_reset_i |=> fdc_auto_pd_o == $past(wdata_i[7]))
    else $error("auto powerdown bit not written");
  chk_hard_reset_pwr: assert property (
    hard_reset_i |=> power_boot_config[7:4] == 4'h0 && !fdc_auto_pd_o)
    else $error("hard reset left power bits");
  chk_hard_keeps_low: assert property (
    hard_reset_i && !wr_data |=> power_boot_config[3:0] == $past(power_boot_config[3:0]))
    else $error("hard reset touched low power bits");
  chk_rsvd_eight_read: assert property (
    rd_i && addr_i == cfr_pkg::ADDR_DATA && cfg_mode && sel_rsvd |=> rdata_o == 8'h00)
    else $error("index eight read nonzero");
  chk_test_write: assert property (
    wr_data && sel_test |=> test_control == $past(wdata_i))
    else $error("test register write lost");
  chk_ecp_rsvd_zero: assert property (
    ecp_level_ir_route[5:4] == 2'h0)
    else $error("ecp reserved bits set");
  chk_ecp_level_out: assert property (
    wr_data && sel_ecp |=> ecp_fifo_level_o == $past(wdata_i[2:0]))
    else $error("ecp level not driven");
  chk_hard_reset_route: assert property (
    hard_reset_i |=> ecp_level_ir_route[7:6] == 2'h0)
    else $error("hard reset left routing");
  chk_route_off: assert property (
    route_ctl_o.tx_hiz == (ecp_level_ir_route[7:6] == 2'h3))
    else $error("off code did not float outputs");
  chk_no_cfg_access: assert property (
    !cfg_mode && rd_i |=> rdata_o == 8'h00 || $past(addr_i) == cfr_pkg::ADDR_MODE)
    else $error("data leaked outside config");
  chk_no_cfg_write: assert property (
    !cfg_mode |=> test_control == $past(test_control))
    else $error("write outside config took effect");

  // ----------------------------------------------------------------
  // checks on read data
  // ----------------------------------------------------------------
  chk_pwr_read: assert property (
    rd_data && sel_pwr |=> rdata_o == $past(power_boot_config))
    else $error("power register read wrong");
  chk_test_read: assert property (
    rd_data && sel_test |=> rdata_o == $past(test_control))
    else $error("test register read wrong");
  chk_ecp_read: assert property (
    rd_data && sel_ecp |=> rdata_o[5:4] == 2'h0
      && rdata_o[7:6] == $past(ecp_level_ir_route[7:6])
      && rdata_o[3:0] == $past(ecp_level_ir_route[3:0]))
    else $error("ecp register read wrong");
  chk_foreign_read: assert property (
    rd_data && !(sel_pwr || sel_rsvd || sel_test || sel_ecp) |=> rdata_o == 8'h00)
    else $error("foreign index returned data");
  chk_rdata_idle: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  chk_index_read: assert property (
    rd_i && addr_i == cfr_pkg::ADDR_INDEX && cfg_mode |=> rdata_o == $past(config_index_reg))
    else $error("index read wrong");
  chk_mode_read: assert property (
    rd_i && addr_i == cfr_pkg::ADDR_MODE |=> rdata_o == {7'h00, $past(cfg_mode)})
    else $error("mode port read wrong");

  // ----------------------------------------------------------------
  // checks on register writes
  // ----------------------------------------------------------------
  chk_pwr_write: assert property (
    wr_data && sel_pwr && !hard_reset_i |=> power_boot_config == $past(wdata_i))
    else $error("power register write lost");
  chk_ecp_route_write: assert property (
    wr_data && sel_ecp && !hard_reset_i |=> ecp_level_ir_route[7:6] == $past(wdata_i[7:6]))
    else $error("routing field write lost");
  chk_ecp_hard_keeps: assert property (
    hard_reset_i && !wr_data |=> ecp_level_ir_route[3:0] == $past(ecp_level_ir_route[3:0]))
    else $error("hard reset touched ecp level");
  chk_rsvd_no_store: assert property (
    wr_data && sel_rsvd && !hard_reset_i |=> power_boot_config == $past(power_boot_config)
      && ecp_level_ir_route == $past(ecp_level_ir_route))
    else $error("index eight write changed a register");
  chk_no_cfg_regs: assert property (
    !cfg_mode && !hard_reset_i |=> power_boot_config == $past(power_boot_config)
      && ecp_level_ir_route == $past(ecp_level_ir_route))
    else $error("register changed outside config");
  chk_index_frozen: assert property (
    !cfg_mode |=> config_index_reg == $past(config_index_reg))
    else $error("index moved outside config");
  chk_index_write: assert property (
    cfg_mode && wr_i && addr_i == cfr_pkg::ADDR_INDEX |=> config_index_reg == $past(wdata_i))
    else $error("index write lost");
  chk_mode_write: assert property (
    wr_i && addr_i == cfr_pkg::ADDR_MODE |=> config_state_o == $past(wdata_i[0]))
    else $error("mode write lost");
  chk_test_wrong_idx: assert property (
    wr_data && !sel_test |=> test_control == $past(test_control))
    else $error("test register written through another index");
  chk_ecp_wrong_idx: assert property (
    wr_data && !sel_ecp && !hard_reset_i |=> ecp_level_ir_route == $past(ecp_level_ir_route))
    else $error("ecp register written through another index");
  chk_test_hard_keeps: assert property (
    hard_reset_i && !wr_data |=> test_control == $past(test_control))
    else $error("hard reset touched test register");

  // ----------------------------------------------------------------
  // checks on control outputs
  // ----------------------------------------------------------------
  chk_fdc_tracks: assert property (
    fdc_auto_pd_o == power_boot_config[cfr_pkg::FDC_APD_BIT])
    else $error("auto powerdown output off its bit");
  chk_level_tracks: assert property (
    ecp_fifo_level_o == ecp_level_ir_route[2:0])
    else $error("fifo level output off its field");
  chk_route_com: assert property (
    route_ctl_o.com_sel == (ecp_level_ir_route[7:6] == 2'h0))
    else $error("com routing wrong");
  chk_route_ir: assert property (
    route_ctl_o.ir_sel == (ecp_level_ir_route[7:6] == 2'h1))
    else $error("ir routing wrong");
  chk_route_rsvd: assert property (
    ecp_level_ir_route[7:6] == 2'h2 |-> route_ctl_o == 3'h0)
    else $error("reserved code drove a control");

  cov_pwr_write: cover property (wr_data && sel_pwr);
  cov_ecp_write: cover property (wr_data && sel_ecp);
  cov_hard_reset: cover property (hard_reset_i && ecp_level_ir_route != 8'h00);
  cov_route_ir: cover property (route_ctl_o.ir_sel);
  cov_route_off: cover property (route_ctl_o.tx_hiz);

endmodule : cfr_regs

// ==== logic/cfr_pkg.sv ====
/*
  package for the configuration register slice: indexes, field positions,
  reset values and the ir routing encodings.
  assumes a byte-wide indexed configuration port in front of it.
*/
package cfr_pkg;

  // ----------------------------------------------------------------
  // register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_POWER_BOOT = 8'h07;
  localparam logic [7:0] IDX_RSVD_EIGHT = 8'h08;
  localparam logic [7:0] IDX_TEST_CTRL = 8'h09;
  localparam logic [7:0] IDX_ECP_IR = 8'h0a;

  // ----------------------------------------------------------------
  // port addresses of the software port
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_INDEX = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  localparam logic [1:0] ADDR_MODE = 2'h2;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] POR_VALUE = 8'h00;
  localparam logic [7:0] RSVD_EIGHT_VALUE = 8'h00;
  localparam logic [7:0] PWR_HARD_KEEP = 8'h0f;
  localparam int FDC_APD_BIT = 7;
  localparam logic [7:0] ECP_WRITE_MASK = 8'hcf;
  localparam logic [7:0] ECP_HARD_KEEP = 8'h3f;
  localparam int ECP_LEVEL_LSB = 0;
  localparam int ECP_LEVEL_W = 3;
  localparam int IR_ROUTE_LSB = 6;

  // ir output routing
  typedef enum logic [1:0] {
    CFR_ROUTE_COM = 2'h0,
    CFR_ROUTE_IR = 2'h1,
    CFR_ROUTE_RSVD = 2'h2,
    CFR_ROUTE_OFF = 2'h3
  } cfr_route_e;

  // routing decoded into pin controls
  typedef struct packed {
    logic com_sel;
    logic ir_sel;
    logic tx_hiz;
  } cfr_route_s;

endpackage : cfr_pkg

// ==== logic/cfr_route_dec.sv ====
/*
  decodes the ir output routing field into registered pin controls.
  assumes the field comes from the same clock domain.
*/
`timescale 1ns/1ps
module cfr_route_dec (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] route_i,
  output cfr_pkg::cfr_route_s ctl_o
);

  cfr_pkg::cfr_route_s next_ctl;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ctl = '0;
    case (route_i)
      cfr_pkg::CFR_ROUTE_COM: next_ctl.com_sel = 1'b1;
      cfr_pkg::CFR_ROUTE_IR: next_ctl.ir_sel = 1'b1;
      cfr_pkg::CFR_ROUTE_OFF: next_ctl.tx_hiz = 1'b1;
      default: next_ctl = '0; // reserved code: nothing routed
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      ctl_o <= '{com_sel: 1'b1, ir_sel: 1'b0, tx_hiz: 1'b0}; // reset code 00 is com
    else
      ctl_o <= next_ctl;
  end

endmodule : cfr_route_dec

// ==== testbench/test_cfr_regs.sv ====
/*
  self-checking bench for the configuration register slice.
  assumes cfr_pkg and cfr_regs are compiled before it.
*/
`timescale 1ns/1ps
module test_cfr_regs;
  logic clk_i;
  logic resetn_i;
  logic hard_reset_i;
  logic [1:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rdata_o;
  logic config_state_o;
  logic fdc_auto_pd_o;
  logic [2:0] ecp_fifo_level_o;
  cfr_pkg::cfr_route_s route_ctl_o;
  int n_fail;
  int total_checks;
  logic [2:0] exp_route [4];
  logic [2:0] lv;

  cfr_regs cfr_regs_inst (.clk_i(clk_i), .resetn_i(resetn_i), .hard_reset_i(hard_reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .config_state_o(config_state_o), .fdc_auto_pd_o(fdc_auto_pd_o),
    .ecp_fifo_level_o(ecp_fifo_level_o), .route_ctl_o(route_ctl_o));

  // ----------------------------------------------------------------
  // clock, tasks and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // compares a read byte
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t read got %h exp %h", $time, got, exp);
    end
  endtask : cmp_rd

  // compares a control output
  task automatic cmp_pin(input logic [2:0] got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask : cmp_pin

  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1; // let the edge's updates settle
  endtask : bus_wr

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    cmp_rd(rdata_o, exp);
  endtask : bus_rd

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    bus_wr(cfr_pkg::ADDR_INDEX, idx);
    bus_wr(cfr_pkg::ADDR_DATA, d);
  endtask : wreg

  task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
    bus_wr(cfr_pkg::ADDR_INDEX, idx);
    bus_rd(cfr_pkg::ADDR_DATA, exp);
  endtask : rreg

  task automatic hard_pulse();
    @(posedge clk_i);
    hard_reset_i <= 1'b1;
    @(posedge clk_i);
    hard_reset_i <= 1'b0;
  endtask : hard_pulse

  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    resetn_i = 1'b0;
    hard_reset_i = 1'b0;
    addr_i = 2'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    n_fail = 0;
    total_checks = 0;
    exp_route = '{3'h4, 3'h2, 3'h0, 3'h1};
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    // power-on values
    bus_wr(cfr_pkg::ADDR_MODE, 8'h01);
    cmp_pin({2'h0, config_state_o}, 3'h1);
    rreg(cfr_pkg::IDX_POWER_BOOT, 8'h00);
    rreg(cfr_pkg::IDX_RSVD_EIGHT, 8'h00);
    rreg(cfr_pkg::IDX_TEST_CTRL, 8'h00);
    rreg(cfr_pkg::IDX_ECP_IR, 8'h00);
    cmp_pin(route_ctl_o, 3'h4);
    $display("test defaults done");
    // floppy powerdown enable and hard reset of the upper nibble
    wreg(cfr_pkg::IDX_POWER_BOOT, 8'h83);
    rreg(cfr_pkg::IDX_POWER_BOOT, 8'h83);
    cmp_pin({2'h0, fdc_auto_pd_o}, 3'h1);
    hard_pulse();
    rreg(cfr_pkg::IDX_POWER_BOOT, 8'h03);
    cmp_pin({2'h0, fdc_auto_pd_o}, 3'h0);
    wreg(cfr_pkg::IDX_RSVD_EIGHT, 8'h5a);
    rreg(cfr_pkg::IDX_RSVD_EIGHT, 8'h00);
    $display("test power done");
    // every routing code with a different fifo level
    for (int i = 0; i < 4; i++)
    begin
      lv = 3'(2 * i + 1);
      wreg(cfr_pkg::IDX_ECP_IR, {i[1:0], 2'h3, 1'b0, lv});
      rreg(cfr_pkg::IDX_ECP_IR, {i[1:0], 2'h0, 1'b0, lv});
      cmp_pin(ecp_fifo_level_o, lv);
      cmp_pin(route_ctl_o, exp_route[i]);
    end
    hard_pulse();
    rreg(cfr_pkg::IDX_ECP_IR, 8'h07);
    cmp_pin(route_ctl_o, 3'h4);
    $display("test ecp done");
    // access outside configuration state and to a foreign index
    bus_wr(cfr_pkg::ADDR_MODE, 8'h00);
    cmp_pin({2'h0, config_state_o}, 3'h0);
    bus_rd(cfr_pkg::ADDR_MODE, 8'h00);
    bus_rd(cfr_pkg::ADDR_INDEX, 8'h00);
    bus_wr(cfr_pkg::ADDR_INDEX, 8'h07);
    bus_wr(cfr_pkg::ADDR_DATA, 8'hc1);
    bus_rd(cfr_pkg::ADDR_DATA, 8'h00);
    bus_wr(cfr_pkg::ADDR_MODE, 8'h01);
    bus_rd(cfr_pkg::ADDR_INDEX, 8'h0a);
    bus_rd(cfr_pkg::ADDR_MODE, 8'h01);
    rreg(cfr_pkg::IDX_ECP_IR, 8'h07);
    rreg(cfr_pkg::IDX_POWER_BOOT, 8'h03);
    rreg(8'h0b, 8'h00);
    $display("test access done");
    close_out();
  end
endmodule : test_cfr_regs
